/* File: bcsup_pkg.sv */
// Constants shared by the breaker and transformer supervision block
package bcsup_pkg;

   // Clock and timer base
   localparam int CLK_PERIOD_NS     = 10;
   localparam int TIMER_TICK_US     = 1000;
   localparam int TICK_CYCLES       = (TIMER_TICK_US * 1000) / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_BF_TIME    = 8'h04;
   localparam logic [7:0] OFF_TC_DELAY   = 8'h08;
   localparam logic [7:0] OFF_BF_THRESH  = 8'h0c;
   localparam logic [7:0] OFF_RATED_PH   = 8'h10;
   localparam logic [7:0] OFF_RATED_E    = 8'h14;
   localparam logic [7:0] OFF_CTS_LIMIT  = 8'h18;
   localparam logic [7:0] OFF_STATUS     = 8'h1c;
   localparam logic [7:0] OFF_CMD        = 8'h20;

   // Control register fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_MODE_MSB  = 1;
   localparam int CTRL_TWO_AUX   = 2;
   localparam int CTRL_CTS_EN    = 3;
   localparam int CTRL_BF_EN     = 4;
   localparam int CTRL_EXTRA_LSB = 5;
   localparam int CTRL_EXTRA_MSB = 7;
   localparam int CTRL_WIDTH     = 8;

   // Command register fields
   localparam int CMD_ACK_LOCK   = 0;

   // Status register fields
   localparam int ST_START    = 0;
   localparam int ST_RUNNING  = 1;
   localparam int ST_TRIP     = 2;
   localparam int ST_LOCK     = 3;
   localparam int ST_TC       = 4;
   localparam int ST_CTS      = 5;
   localparam int ST_REJECTED = 6;
   localparam int ST_WIDTH    = 7;

   // Reset values
   localparam logic [7:0]  RST_CTRL       = 8'h00;
   localparam logic [15:0] RST_BF_TIME    = 16'h0064;
   localparam logic [15:0] RST_TC_DELAY   = 16'h03e8;
   localparam logic [15:0] RST_BF_THRESH  = 16'h0100;
   localparam logic [31:0] RST_RATED      = 32'h0001_0001;
   localparam logic [31:0] RST_CTS_LIMIT  = 32'h0000_0100;

   // Error factor is unsigned with this many fraction bits
   localparam int PEF_FRAC = 8;

   // Width of the synchronised pin group
   localparam int N_PINS = 5;

   typedef enum logic [1:0] {
      BCSUP_TRIG_NONE = 2'b00,
      BCSUP_TRIG_ALL  = 2'b01,
      BCSUP_TRIG_EXT  = 2'b10,
      BCSUP_TRIG_CUR  = 2'b11
   } bcsup_trig_t;

   typedef enum logic [1:0] {
      BCSUP_IDLE     = 2'b00,
      BCSUP_RUN      = 2'b01,
      BCSUP_TRIPPED  = 2'b10,
      BCSUP_REJECTED = 2'b11
   } bcsup_state_t;

endpackage : bcsup_pkg

/* File: bcsup_delay_timer.sv */
// Restartable millisecond delay timer with its own prescaler
`timescale 1ns/1ps
module bcsup_delay_timer #(
   parameter int TICK_CYCLES = 100000
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [15:0] limit,
   output logic             expired
);

   logic [16:0] pre_q;
   logic [16:0] pre_d;
   logic [15:0] ms_q;
   logic [15:0] ms_d;
   logic        tick;

   // Own prescaler so the delay starts exactly at run, no tick phase jitter
   assign tick    = (pre_q == 17'(TICK_CYCLES - 1));
   assign expired = run && (ms_q >= limit);
   assign pre_d   = (!run || expired) ? 17'h00000 : (tick ? 17'h00000 : pre_q + 17'h00001);
   assign ms_d    = !run ? 16'h0000 : ((tick && !expired) ? ms_q + 16'h0001 : ms_q);

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pre_q <= 17'h00000;
         ms_q  <= 16'h0000;
      end else begin
         pre_q <= pre_d;
         ms_q  <= ms_d;
      end
   end

endmodule : bcsup_delay_timer

/* File: bcsup_top.sv */
// Breaker failure start, trip circuit watch and current transformer supervision
// Operation
// - Mode all trips: every routed trip starts breaker failure supervision
// - Mode external: only routed external trips start the supervision
// - Mode current: only routed current protection trips start the supervision
// - Mode none: only the extra start inputs can start supervision
// - Three extra start inputs start supervision even when not routed; here each needs its enable bit in the control register extra field
// - Failure trip follows first start activation by the supervision delay
// - No pickup when current below threshold with breaker off
// - Single closed contact: trip circuit evaluated only while breaker closed
// - Both contacts: trip circuit evaluated continuously in either breaker position
// - Broken trip circuit alarms only after the alarm delay expires
// - Loss of trip circuit supply counts as failure, alarmed after delay
// - Residual sum is three phase phasors plus factor scaled earth current
// - Earth ratio factor derived from rated primary and secondary currents
// - Limit is base deviation plus error factor times largest phase current
// - Residual magnitude at or above limit raises transformer alarm
// - Any start launches the timer, which runs on if start drops
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module bcsup_top #(
   parameter int TICK_CYCLES = bcsup_pkg::TICK_CYCLES
) (
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic [7:0]         trip_req,
   input  wire logic [7:0]         trip_is_ext,
   input  wire logic [7:0]         trip_is_cur,
   input  wire logic [2:0]         extra_start_input,
   input  wire logic               closed_aux_contact,
   input  wire logic               open_aux_contact,
   input  wire logic               breaker_closed,
   input  wire logic signed [15:0] phase_current_first_re,
   input  wire logic signed [15:0] phase_current_first_im,
   input  wire logic signed [15:0] phase_current_second_re,
   input  wire logic signed [15:0] phase_current_second_im,
   input  wire logic signed [15:0] phase_current_third_re,
   input  wire logic signed [15:0] phase_current_third_im,
   input  wire logic signed [15:0] measured_earth_current_re,
   input  wire logic signed [15:0] measured_earth_current_im,
   output logic                    breaker_failure_start,
   output logic                    breaker_failure_trip,
   output logic                    breaker_failure_lockout,
   output logic                    trip_circuit_alarm,
   output logic                    ct_failure_alarm
);

   // Pin synchronisers
   logic [bcsup_pkg::N_PINS-1:0] pin_raw;
   logic [bcsup_pkg::N_PINS-1:0] pin_meta_q;
   logic [bcsup_pkg::N_PINS-1:0] pin_sync_q;
   logic [2:0]                   extra_s;
   logic                         closed_aux_s;
   logic                         open_aux_s;

   assign pin_raw      = {open_aux_contact, closed_aux_contact, extra_start_input};
   assign extra_s      = pin_sync_q[2:0];
   assign closed_aux_s = pin_sync_q[3];
   assign open_aux_s   = pin_sync_q[4];

   genvar gi;
   generate
      for (gi = 0; gi < bcsup_pkg::N_PINS; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               pin_meta_q[gi] <= 1'b0;
               pin_sync_q[gi] <= 1'b0;
            end else begin
               pin_meta_q[gi] <= pin_raw[gi];
               pin_sync_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   // Register file
   logic [bcsup_pkg::CTRL_WIDTH-1:0] ctrl_q;
   logic [15:0]                      bf_time_q;
   logic [15:0]                      tc_delay_q;
   logic [15:0]                      bf_thresh_q;
   logic [31:0]                      rated_ph_q;
   logic [31:0]                      rated_e_q;
   logic [31:0]                      cts_limit_q;
   logic [31:0]                      prdata_q;
   logic [31:0]                      rd_mux;
   logic                             wr_en;
   logic                             rd_setup;
   logic                             hit_ctrl;
   logic                             hit_bf_time;
   logic                             hit_tc_delay;
   logic                             hit_thresh;
   logic                             hit_rated_ph;
   logic                             hit_rated_e;
   logic                             hit_limit;
   logic                             hit_status;
   logic                             hit_cmd;
   logic                             mapped;
   logic                             ack_lock;
   logic [bcsup_pkg::ST_WIDTH-1:0]   status;

   assign hit_ctrl      = (paddr == bcsup_pkg::OFF_CTRL);
   assign hit_bf_time   = (paddr == bcsup_pkg::OFF_BF_TIME);
   assign hit_tc_delay  = (paddr == bcsup_pkg::OFF_TC_DELAY);
   assign hit_thresh    = (paddr == bcsup_pkg::OFF_BF_THRESH);
   assign hit_rated_ph  = (paddr == bcsup_pkg::OFF_RATED_PH);
   assign hit_rated_e   = (paddr == bcsup_pkg::OFF_RATED_E);
   assign hit_limit     = (paddr == bcsup_pkg::OFF_CTS_LIMIT);
   assign hit_status    = (paddr == bcsup_pkg::OFF_STATUS);
   assign hit_cmd       = (paddr == bcsup_pkg::OFF_CMD);
   assign mapped        = hit_ctrl | hit_bf_time | hit_tc_delay | hit_thresh | hit_rated_ph
                        | hit_rated_e | hit_limit | hit_status | hit_cmd;

   // Zero wait states; read data is captured in the setup cycle
   assign wr_en    = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign ack_lock = wr_en && hit_cmd && pwdata[bcsup_pkg::CMD_ACK_LOCK];
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_q;

   assign rd_mux = hit_ctrl      ? {24'h000000, ctrl_q} :
                   hit_bf_time   ? {16'h0000, bf_time_q} :
                   hit_tc_delay  ? {16'h0000, tc_delay_q} :
                   hit_thresh    ? {16'h0000, bf_thresh_q} :
                   hit_rated_ph  ? rated_ph_q :
                   hit_rated_e   ? rated_e_q :
                   hit_limit     ? cts_limit_q :
                   hit_status    ? {25'h0000000, status} : 32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_q       <= bcsup_pkg::RST_CTRL;
         bf_time_q    <= bcsup_pkg::RST_BF_TIME;
         tc_delay_q   <= bcsup_pkg::RST_TC_DELAY;
         bf_thresh_q  <= bcsup_pkg::RST_BF_THRESH;
         rated_ph_q   <= bcsup_pkg::RST_RATED;
         rated_e_q    <= bcsup_pkg::RST_RATED;
         cts_limit_q  <= bcsup_pkg::RST_CTS_LIMIT;
      end else if (wr_en) begin
         if (hit_ctrl)      ctrl_q       <= pwdata[bcsup_pkg::CTRL_WIDTH-1:0];
         if (hit_bf_time)   bf_time_q    <= pwdata[15:0];
         if (hit_tc_delay)  tc_delay_q   <= pwdata[15:0];
         if (hit_thresh)    bf_thresh_q  <= pwdata[15:0];
         if (hit_rated_ph)  rated_ph_q   <= pwdata;
         if (hit_rated_e)   rated_e_q    <= pwdata;
         if (hit_limit)     cts_limit_q  <= pwdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         prdata_q <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_q <= rd_mux;
      end
   end

   // Approximate magnitude: larger part plus half the smaller, at most 12 % high
   function automatic logic [59:0] bcsup_mag(input logic signed [59:0] re, input logic signed [59:0] im);
      logic [59:0] a;
      logic [59:0] b;
      a = re[59] ? 60'(-re) : 60'(re);
      b = im[59] ? 60'(-im) : 60'(im);
      bcsup_mag = (a > b) ? a + (b >> 1) : b + (a >> 1);
   endfunction : bcsup_mag

   // Phase magnitudes and largest phase current
   logic [59:0] mag_first;
   logic [59:0] mag_second;
   logic [59:0] mag_third;
   logic [59:0] imax;
   logic [59:0] imax_12;

   assign mag_first  = bcsup_mag(60'(phase_current_first_re), 60'(phase_current_first_im));
   assign mag_second = bcsup_mag(60'(phase_current_second_re), 60'(phase_current_second_im));
   assign mag_third  = bcsup_mag(60'(phase_current_third_re), 60'(phase_current_third_im));
   assign imax_12    = (mag_first > mag_second) ? mag_first : mag_second;
   assign imax       = (imax_12 > mag_third) ? imax_12 : mag_third;

   // Ratio factor kept as numerator and denominator to avoid a divider
   logic [31:0] ratio_num_q;
   logic [31:0] ratio_den_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ratio_num_q <= 32'h00000001;
         ratio_den_q <= 32'h00000001;
      end else begin
         ratio_num_q <= rated_e_q[15:0] * rated_ph_q[31:16];
         ratio_den_q <= rated_e_q[31:16] * rated_ph_q[15:0];
      end
   end

   // Residual sum scaled by the denominator of the ratio factor
   logic signed [59:0] sum_re;
   logic signed [59:0] sum_im;
   logic signed [59:0] res_re;
   logic signed [59:0] res_im;
   logic [59:0]        res_mag;
   logic [59:0]        pef_term;
   logic [59:0]        limit_scaled;
   logic               cts_fault;

   assign sum_re = 60'(phase_current_first_re) + 60'(phase_current_second_re) + 60'(phase_current_third_re);
   assign sum_im = 60'(phase_current_first_im) + 60'(phase_current_second_im) + 60'(phase_current_third_im);
   assign res_re = sum_re * $signed({28'h0000000, ratio_den_q})
                 + 60'(measured_earth_current_re) * $signed({28'h0000000, ratio_num_q});
   assign res_im = sum_im * $signed({28'h0000000, ratio_den_q})
                 + 60'(measured_earth_current_im) * $signed({28'h0000000, ratio_num_q});
   assign res_mag = bcsup_mag(res_re, res_im);
   assign pef_term = (60'(cts_limit_q[31:16]) * imax) >> bcsup_pkg::PEF_FRAC;
   assign limit_scaled = (60'(cts_limit_q[15:0]) + pef_term) * 60'(ratio_den_q);
   // Enable bit lets software follow the two-phase and no-earth-CT advice
   assign cts_fault = ctrl_q[bcsup_pkg::CTRL_CTS_EN] && (res_mag >= limit_scaled);

   // Trip circuit watch
   logic tc_fault;
   logic tc_expired;

   // Single contact: an open breaker de-energises the input, so only judge when closed
   assign tc_fault = ctrl_q[bcsup_pkg::CTRL_TWO_AUX] ? !(closed_aux_s || open_aux_s)
                                                     : (breaker_closed && !closed_aux_s);

   bcsup_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tc_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .run     (tc_fault),
      .limit   (tc_delay_q),
      .expired (tc_expired)
   );

   // Breaker failure start selection
   logic [1:0] trig_mode;
   logic       start_all;
   logic       start_ext;
   logic       start_cur;
   logic       start_mode;
   logic       start_extra;
   logic       start_comb;
   logic       below_thr;
   logic       breaker_open;
   logic       pickup;
   logic       bf_expired;

   assign trig_mode   = ctrl_q[bcsup_pkg::CTRL_MODE_MSB:bcsup_pkg::CTRL_MODE_LSB];
   assign start_all   = |trip_req;
   assign start_ext   = |(trip_req & trip_is_ext);
   assign start_cur   = |(trip_req & trip_is_cur);
   assign start_mode  = (trig_mode == bcsup_pkg::BCSUP_TRIG_ALL) ? start_all :
                        (trig_mode == bcsup_pkg::BCSUP_TRIG_EXT) ? start_ext :
                        (trig_mode == bcsup_pkg::BCSUP_TRIG_CUR) ? start_cur : 1'b0;
   assign start_extra = |(extra_s & ctrl_q[bcsup_pkg::CTRL_EXTRA_MSB:bcsup_pkg::CTRL_EXTRA_LSB]);
   assign start_comb  = ctrl_q[bcsup_pkg::CTRL_BF_EN] && (start_mode || start_extra);
   assign below_thr   = imax < 60'(bf_thresh_q);
   assign breaker_open = ctrl_q[bcsup_pkg::CTRL_TWO_AUX] ? open_aux_s : !breaker_closed;
   assign pickup      = start_comb && !(below_thr && breaker_open);

   // Breaker failure sequence
   bcsup_pkg::bcsup_state_t state_q;
   bcsup_pkg::bcsup_state_t state_d;
   logic                    lock_q;
   logic                    lock_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bcsup_pkg::BCSUP_IDLE: begin
            if (pickup) state_d = bcsup_pkg::BCSUP_RUN;
         end
         bcsup_pkg::BCSUP_RUN: begin
            // Timer stays running after the start drops; only current below threshold stops it
            if (below_thr) state_d = bcsup_pkg::BCSUP_REJECTED;
            else if (bf_expired) state_d = bcsup_pkg::BCSUP_TRIPPED;
         end
         bcsup_pkg::BCSUP_TRIPPED: begin
            if (!start_comb) state_d = bcsup_pkg::BCSUP_IDLE;
         end
         bcsup_pkg::BCSUP_REJECTED: begin
            if (!start_comb) state_d = bcsup_pkg::BCSUP_IDLE;
         end
      endcase
   end

   // Set wins over an acknowledge in the same cycle
   assign lock_d = (state_d == bcsup_pkg::BCSUP_TRIPPED && state_q != bcsup_pkg::BCSUP_TRIPPED)
                 || (lock_q && !ack_lock);

   bcsup_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_bf_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .run     (state_q == bcsup_pkg::BCSUP_RUN),
      .limit   (bf_time_q),
      .expired (bf_expired)
   );

   // Output flops
   logic start_q;
   logic tc_alarm_q;
   logic cts_alarm_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q     <= bcsup_pkg::BCSUP_IDLE;
         lock_q      <= 1'b0;
         start_q     <= 1'b0;
         tc_alarm_q  <= 1'b0;
         cts_alarm_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         lock_q      <= lock_d;
         start_q     <= pickup;
         tc_alarm_q  <= tc_fault && tc_expired;
         cts_alarm_q <= cts_fault;
      end
   end

   assign breaker_failure_start   = start_q;
   assign breaker_failure_trip    = (state_q == bcsup_pkg::BCSUP_TRIPPED);
   assign breaker_failure_lockout = lock_q;
   assign trip_circuit_alarm      = tc_alarm_q;
   assign ct_failure_alarm        = cts_alarm_q;

   assign status = {(state_q == bcsup_pkg::BCSUP_REJECTED), cts_alarm_q, tc_alarm_q, lock_q,
                    (state_q == bcsup_pkg::BCSUP_TRIPPED), (state_q == bcsup_pkg::BCSUP_RUN), start_q};

endmodule : bcsup_top

/* File: bcsup_sva.sv */
// Port checker for the supervision block
`timescale 1ns/1ps
module bcsup_sva (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        closed_aux_contact,
   input wire logic        open_aux_contact,
   input wire logic        breaker_failure_start,
   input wire logic        breaker_failure_trip,
   input wire logic        breaker_failure_lockout,
   input wire logic        trip_circuit_alarm,
   input wire logic        ct_failure_alarm
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire logic acc;
   wire logic unm;
   wire logic ack;
   assign acc = psel && penable;
   assign unm = paddr > 8'h20 || paddr[1:0] != 2'h0;
   assign ack = acc && pwrite && paddr == 8'h20 && pwdata[0];
   // Closed contact made is healthy in either wiring
   sequence s_healthy;
      closed_aux_contact [*5];
   endsequence
   sequence s_stat_rd;
      acc && !pwrite && paddr == 8'h1c;
   endsequence
   a_ready_always: assert property (pready) else $error("pready low");
   a_err_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
   a_err_unmapped: assert property (acc && unm |-> pslverr) else $error("unmapped without pslverr");
   a_unmapped_zero: assert property (acc && !pwrite && unm |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_stat_mirror: assert property (s_stat_rd |-> prdata[5:2] == $past({ct_failure_alarm,
      trip_circuit_alarm, breaker_failure_lockout, breaker_failure_trip})) else $error("status mismatch");
   a_lock_with_trip: assert property ($rose(breaker_failure_trip) |-> breaker_failure_lockout)
      else $error("lockout late");
   a_lock_holds: assert property (breaker_failure_lockout && !ack |=> breaker_failure_lockout)
      else $error("lockout lost");
   a_trip_release: assert property ($fell(breaker_failure_trip) |-> !breaker_failure_start)
      else $error("trip fell with start");
   a_loop_clear: assert property (s_healthy |=> !trip_circuit_alarm)
      else $error("alarm on healthy loop");
   a_reset_clear: assert property ($rose(nrst) |-> !(breaker_failure_start || breaker_failure_trip
      || breaker_failure_lockout || trip_circuit_alarm || ct_failure_alarm)) else $error("reset dirty");
endmodule : bcsup_sva
bind bcsup_top bcsup_sva u_sva (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
   .prdata, .pready, .pslverr, .closed_aux_contact, .open_aux_contact, .breaker_failure_start,
   .breaker_failure_trip, .breaker_failure_lockout, .trip_circuit_alarm, .ct_failure_alarm);

/* File: bcsup_breaker_model.sv */
// Breaker contacts and trip circuit supply model
`timescale 1ns/1ps
module bcsup_breaker_model (
   input  wire logic closed_pos,
   input  wire logic supply_on,
   input  wire logic wire_broken,
   output logic      closed_aux_contact,
   output logic      open_aux_contact,
   output logic      breaker_closed
);
   // Supply feeds the inputs too, so loss reads low on both
   assign closed_aux_contact = supply_on && !wire_broken && closed_pos;
   assign open_aux_contact   = supply_on && !wire_broken && !closed_pos;
   assign breaker_closed     = closed_pos;
endmodule : bcsup_breaker_model

/* File: bcsup_tb_top.sv */
// Self-checking bench for the supervision block
`timescale 1ns/1ps
module bcsup_tb_top;
   localparam int TK = 10;
   logic               sys_clk = 1'b0;
   logic               nrst = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]        pwdata = 32'h0, prdata;
   logic               pready, pslverr;
   logic [7:0]         trip_req = 8'h00, trip_is_ext = 8'h00, trip_is_cur = 8'h00;
   logic [2:0]         extra_start_input = 3'h0;
   logic               closed_pos = 1'b1, supply_on = 1'b1, wire_broken = 1'b0;
   logic               closed_aux_contact, open_aux_contact, breaker_closed;
   logic signed [15:0] ia = 16'sh0, ib = 16'sh0, ic = 16'sh0, ie = 16'sh0;
   logic               bf_start, bf_trip, bf_lock, tc_alarm, ct_alarm;
   int                 error_cnt = 0, num_checks = 0, cyc = 0;

   bcsup_top #(.TICK_CYCLES(TK)) DUT (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .trip_req, .trip_is_ext, .trip_is_cur, .extra_start_input,
      .closed_aux_contact, .open_aux_contact, .breaker_closed,
      .phase_current_first_re(ia), .phase_current_first_im(16'sh0),
      .phase_current_second_re(ib), .phase_current_second_im(16'sh0),
      .phase_current_third_re(ic), .phase_current_third_im(16'sh0),
      .measured_earth_current_re(ie), .measured_earth_current_im(16'sh0),
      .breaker_failure_start(bf_start), .breaker_failure_trip(bf_trip),
      .breaker_failure_lockout(bf_lock), .trip_circuit_alarm(tc_alarm), .ct_failure_alarm(ct_alarm));
   bcsup_breaker_model u_brk (.closed_pos, .supply_on, .wire_broken, .closed_aux_contact,
      .open_aux_contact, .breaker_closed);

   always #5 sys_clk = ~sys_clk;

   task automatic end_sim();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cy(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cy

   // Idle cycle after each transfer keeps strobes single-assigned
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      psel   <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(a, 1'b1, d, r);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask : rdc

   task automatic t_regs();
      rdc(8'h04, 32'h0000_0064);
      rdc(8'h08, 32'h0000_03e8);
      rdc(8'h0c, 32'h0000_0100);
      rdc(8'h24, 32'h0);
      wr(8'h1c, 32'hffff_ffff);
      rdc(8'h1c, 32'h0);
   endtask : t_regs

   task automatic t_modes();
      trip_is_ext <= 8'h01;
      trip_is_cur <= 8'h02;
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 32'h10 | m);
         for (int b = 0; b < 3; b++) begin
            trip_req <= 8'h01 << b;
            cy(3);
            chk(bf_start, m == 1 || (m == 2 && b == 0) || (m == 3 && b == 1));
            trip_req <= 8'h00;
            cy(30);
         end
      end
   endtask : t_modes

   task automatic t_extra();
      wr(8'h00, 32'h0000_00f0);
      for (int b = 0; b < 3; b++) begin
         extra_start_input <= 3'h1 << b;
         cy(5);
         chk(bf_start, 1'b1);
         extra_start_input <= 3'h0;
         cy(40);
      end
   endtask : t_extra

   // Pulsed start must still trip: the timer runs on
   task automatic t_timer(input logic hold);
      int n;
      n = 0;
      wr(8'h00, 32'h11);
      wr(8'h04, 32'h3);
      trip_req <= 8'h01;
      @(posedge sys_clk);
      if (!hold) trip_req <= 8'h00;
      while (bf_start !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      n = 0;
      while (bf_trip !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n, 3 * TK + 1);
      chk(bf_lock, 1'b1);
      trip_req <= 8'h00;
      cy(3);
      chk(bf_trip, 1'b0);
      wr(8'h20, 32'h1);
      chk(bf_lock, 1'b0);
   endtask : t_timer

   task automatic t_gate();
      closed_pos <= 1'b0;
      ia <= 16'sh0;
      trip_req <= 8'h01;
      cy(4);
      chk(bf_start, 1'b0);
      ia <= 16'sh0200;
      cy(3);
      chk(bf_start, 1'b1);
      ia <= 16'sh0;
      cy(40);
      chk(bf_trip, 1'b0);
      trip_req <= 8'h00;
      closed_pos <= 1'b1;
      cy(4);
   endtask : t_gate

   // Delay plus one register and two sync stages, seen one edge later
   task automatic t_trc(input logic [31:0] ctl, input logic pos, sup, brk, glitch, input int exp);
      int n;
      n = 0;
      wr(8'h00, ctl);
      closed_pos <= pos;
      cy(8);
      supply_on <= sup;
      wire_broken <= brk;
      if (glitch) begin
         cy(15);
         wire_broken <= 1'b0;
         @(posedge sys_clk);
         wire_broken <= brk;
      end
      while (tc_alarm !== 1'b1 && n < 60) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n, exp);
      supply_on <= 1'b1;
      wire_broken <= 1'b0;
      closed_pos <= 1'b1;
      cy(6);
      chk(tc_alarm, 1'b0);
   endtask : t_trc

   // Phasors on the real axis keep the magnitude exact
   task automatic t_ct(input logic en, input logic [31:0] rat, lim, input logic signed [15:0] a, b, c, e,
                       input logic exp);
      wr(8'h00, {28'h0, en, 3'h0});
      wr(8'h14, rat);
      wr(8'h18, lim);
      ia <= a;
      ib <= b;
      ic <= c;
      ie <= e;
      cy(4);
      chk(ct_alarm, exp);
   endtask : t_ct

   initial begin
      cy(3);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      wr(8'h04, 32'h2);
      wr(8'h08, 32'h2);
      ia <= 16'sh0200;
      t_modes();
      t_extra();
      t_timer(1'b0);
      t_timer(1'b1);
      t_gate();
      t_trc(32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 60);
      t_trc(32'h0, 1'b1, 1'b1, 1'b1, 1'b0, 2 * TK + 4);
      t_trc(32'h0, 1'b1, 1'b1, 1'b1, 1'b1, 2 * TK + 4);
      t_trc(32'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2 * TK + 4);
      t_trc(32'h4, 1'b0, 1'b1, 1'b1, 1'b0, 2 * TK + 4);
      t_trc(32'h4, 1'b1, 1'b1, 1'b0, 1'b0, 60);
      t_ct(1'b1, 32'h0001_0001, 32'h10, 16'sh64, -16'sh3c, -16'sh28, 16'sh0, 1'b0);
      t_ct(1'b1, 32'h0001_0001, 32'h10, 16'sh64, 16'sh0, 16'sh0, -16'sh54, 1'b1);
      t_ct(1'b1, 32'h0001_0001, 32'h10, 16'sh64, 16'sh0, 16'sh0, -16'sh55, 1'b0);
      t_ct(1'b1, 32'h0001_0002, 32'h10, 16'sh64, 16'sh0, 16'sh0, -16'sh32, 1'b0);
      t_ct(1'b1, 32'h0001_0001, 32'h0100_0010, 16'sh64, 16'sh0, 16'sh0, 16'sh10, 1'b1);
      t_ct(1'b1, 32'h0001_0001, 32'h0100_0010, 16'sh64, 16'sh0, 16'sh0, 16'sh0f, 1'b0);
      t_ct(1'b0, 32'h0001_0001, 32'h10, 16'sh64, 16'sh0, 16'sh0, 16'sh0, 1'b0);
      end_sim();
   end
endmodule : bcsup_tb_top
